// >>> lbri_pkg.sv
// Package: constants and carrier types for the local-bus RAM and I/O latch
package lbri_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Address map (byte addresses on the local bus)
    localparam logic [31:0] LBRI_RAM_FIRST  = 32'h0000_0000;
    localparam logic [31:0] LBRI_RAM_LAST   = 32'h0000_5fff;
    localparam logic [31:0] LBRI_IO_FIRST   = 32'h0000_6000;
    localparam logic [31:0] LBRI_IO_LAST    = 32'h0000_6001;
    localparam logic [31:0] LBRI_SPACE_LAST = 32'h0000_7fff;

    ////////////////////////////////////////////////////////////////////////
    // Memory geometry
    localparam int LBRI_RAM_BYTES = 24576;
    localparam int LBRI_RAM_WORDS = 6144;
    localparam int LBRI_RAM_AW    = 13;
    localparam int LBRI_IO_W      = 16;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] LBRI_IO_RESET   = 16'h0000;
    localparam logic [31:0] LBRI_DATA_ZERO  = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Local bus width codes, as configured in the bridge
    localparam logic [1:0] LBRI_BW_8  = 2'h0;
    localparam logic [1:0] LBRI_BW_16 = 2'h1;
    localparam logic [1:0] LBRI_BW_32 = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Local bus request from the bridge
    typedef struct packed {
        logic        ads;
        logic        blast;
        logic        write_not_read;
        logic [31:0] addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } lbri_req_t;

    // Answer to the bridge
    typedef struct packed {
        logic        ready;
        logic [31:0] rdata;
    } lbri_rsp_t;

    // Bus phase
    typedef enum logic [2:0] {
        LBRI_IDLE = 3'b001,
        LBRI_DATA = 3'b010,
        LBRI_ACK  = 3'b100
    } lbri_state_t;

    // Target of the current access
    typedef enum logic [1:0] {
        LBRI_TGT_NONE = 2'h0,
        LBRI_TGT_RAM  = 2'h1,
        LBRI_TGT_IO   = 2'h2
    } lbri_tgt_t;

endpackage

// >>> lbri_ram.sv
// Synchronous dword RAM with byte-lane writes
`timescale 1ns/1ps
module lbri_ram
    import lbri_pkg::*;
#(
    parameter int WORDS = LBRI_RAM_WORDS,
    parameter int AW    = LBRI_RAM_AW
) (
    // Clock
    input  wire logic          clk,
    // Access port
    input  wire logic [AW-1:0] addr,
    input  wire logic          we,
    input  wire logic [3:0]    byte_en,
    input  wire logic [31:0]   wdata,
    output logic      [31:0]   rdata
);

    initial begin
        if (WORDS > (1 << AW) || WORDS < 1)
            $error("lbri_ram: WORDS does not fit AW");
    end

    logic [31:0] mem [WORDS];

    ////////////////////////////////////////////////////////////////////////
    // Only enabled lanes change; read is registered
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (we && byte_en[i]) begin
                mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
            end
        end
        rdata <= mem[addr];
    end

endmodule // lbri_ram

// >>> lbri_top.sv
// Local-bus glue: 24-Kbyte RAM and 16-bit I/O latch
//
// Function
// - Synchronous RAM of 24 Kbytes, 6k locations of four bytes.
// - Byte, word and dword access via byte lanes; bursts are served.
// - 16-bit output latch drives its pins statically until rewritten.
// - Reading the I/O location returns live levels of 16 input pins.
// - I/O function uses 16 input-only and 16 output-only pins.
// - One address: writes load the latch, reads sample the inputs.
// - With outputs bridged to inputs, read returns last written word.
// - Addresses 0x0000 to 0x5FFF decode to the RAM.
// - 0x6000 to 0x6001 decode to the I/O register; rest unused.
// - Bus carries 8, 16 or 32 bit data, up to 32 bit address.
// - Transfers paced by request, grant, ready and direction.
`timescale 1ns/1ps
module lbri_top
    import lbri_pkg::*;
#(
    parameter logic [1:0] BUS_WIDTH = LBRI_BW_32
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Bus ownership
    input  wire logic                 local_bus_request,
    output logic                      local_bus_grant,
    // Local bus cycle
    input  wire lbri_req_t            req,
    output lbri_rsp_t                 rsp,
    // I/O pins
    input  wire logic [LBRI_IO_W-1:0] io_in,
    output logic      [LBRI_IO_W-1:0] io_out
);

    initial begin
        if (BUS_WIDTH != LBRI_BW_8 && BUS_WIDTH != LBRI_BW_16
            && BUS_WIDTH != LBRI_BW_32)
            $error("lbri_top: unsupported BUS_WIDTH");
    end

    initial begin
        if (LBRI_RAM_WORDS * 4 != LBRI_RAM_BYTES
            || LBRI_RAM_LAST + 1 != LBRI_RAM_BYTES)
            $error("lbri_top: RAM size does not fill its address range");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        lbri_state_t      state;
        lbri_tgt_t        tgt;
        logic             wnr;
        logic [31:0]      addr;
        logic [3:0]       be;
        logic [31:0]      wdata;
        logic             last;
        logic             grant;
        logic             ready;
        logic [31:0]      rdata;
        logic [LBRI_IO_W-1:0] latch;
    } lbri_regs_t;

    lbri_regs_t s_reg;
    lbri_regs_t s_next;

    logic [31:0] ram_rdata;
    logic [LBRI_RAM_AW-1:0] ram_addr;
    logic        ram_we;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic lbri_tgt_t decode(input logic [31:0] a);
        logic [31:0] off;
        off = a & LBRI_SPACE_LAST;
        if (off <= LBRI_RAM_LAST)
            decode = LBRI_TGT_RAM;
        else if (off >= LBRI_IO_FIRST && off <= LBRI_IO_LAST)
            decode = LBRI_TGT_IO;
        else
            decode = LBRI_TGT_NONE;
    endfunction

    // Lanes used by a narrow bus come from the low address bits
    function automatic logic [3:0] lanes(input logic [31:0] a,
                                         input logic [3:0]  be);
        case (BUS_WIDTH)
            LBRI_BW_8:  lanes = 4'h1 << a[1:0];
            LBRI_BW_16: lanes = a[1] ? 4'hc : 4'h3;
            default:    lanes = be;
        endcase
    endfunction

    // Narrow bus data travels on the low lanes
    function automatic logic [31:0] to_lanes(input logic [31:0] a,
                                             input logic [31:0] d);
        case (BUS_WIDTH)
            LBRI_BW_8:  to_lanes = {4{d[7:0]}};
            LBRI_BW_16: to_lanes = {2{d[15:0]}};
            default:    to_lanes = d;
        endcase
    endfunction

    function automatic logic [31:0] from_lanes(input logic [31:0] a,
                                               input logic [31:0] d);
        logic [31:0] sh;
        sh = d >> {a[1:0], 3'h0};
        case (BUS_WIDTH)
            LBRI_BW_8:  from_lanes = {24'h00_0000, sh[7:0]};
            LBRI_BW_16: from_lanes = {16'h0000, sh[15:0]};
            default:    from_lanes = d;
        endcase
    endfunction

    function automatic logic [31:0] next_addr(input logic [31:0] a);
        case (BUS_WIDTH)
            LBRI_BW_8:  next_addr = a + 32'h1;
            LBRI_BW_16: next_addr = a + 32'h2;
            default:    next_addr = a + 32'h4;
        endcase
    endfunction

    // Input pins sit on the two low lanes; the upper lanes read zero
    function automatic logic [31:0] io_word(input logic [LBRI_IO_W-1:0] p);
        io_word = {{(32-LBRI_IO_W){1'b0}}, p};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // RAM
    assign ram_addr = s_reg.addr[LBRI_RAM_AW+1:2];
    assign ram_we   = (s_reg.state == LBRI_DATA) && s_reg.wnr
                      && (s_reg.tgt == LBRI_TGT_RAM);

    lbri_ram #(
        .WORDS (LBRI_RAM_WORDS),
        .AW    (LBRI_RAM_AW)
    ) lbri_ram_i (
        .clk     (clk),
        .addr    (ram_addr),
        .we      (ram_we),
        .byte_en (s_reg.be),
        .wdata   (s_reg.wdata),
        .rdata   (ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_next       = s_reg;
        s_next.ready = 1'b0;
        s_next.grant = local_bus_request;
        case (s_reg.state)
            LBRI_IDLE: begin
                if (req.ads) begin
                    s_next.state = LBRI_DATA;
                    s_next.tgt   = decode(req.addr);
                    s_next.wnr   = req.write_not_read;
                    s_next.addr  = req.addr;
                    s_next.be    = lanes(req.addr, req.byte_en);
                    s_next.wdata = to_lanes(req.addr, req.wdata);
                    s_next.last  = req.blast;
                end
            end
            LBRI_DATA: begin
                // RAM write or read address is applied this cycle
                if (s_reg.wnr && s_reg.tgt == LBRI_TGT_IO) begin
                    if (s_reg.be[0])
                        s_next.latch[7:0] = s_reg.wdata[7:0];
                    if (s_reg.be[1])
                        s_next.latch[15:8] = s_reg.wdata[15:8];
                    // Upper lanes are unused addresses: ignored
                end
                s_next.state = LBRI_ACK;
            end
            LBRI_ACK: begin
                s_next.ready = 1'b1;
                case (s_reg.tgt)
                    LBRI_TGT_RAM:
                        s_next.rdata = s_reg.wnr ? LBRI_DATA_ZERO
                            : from_lanes(s_reg.addr, ram_rdata);
                    LBRI_TGT_IO:
                        s_next.rdata = s_reg.wnr ? LBRI_DATA_ZERO
                            : from_lanes(s_reg.addr, io_word(io_in));
                    default:
                        s_next.rdata = LBRI_DATA_ZERO;
                endcase
                if (s_reg.last) begin
                    s_next.state = LBRI_IDLE;
                end else begin
                    s_next.state = LBRI_DATA;
                    s_next.addr  = next_addr(s_reg.addr);
                    s_next.tgt   = decode(next_addr(s_reg.addr));
                    s_next.be    = lanes(next_addr(s_reg.addr),
                                         req.byte_en);
                    s_next.wdata = to_lanes(next_addr(s_reg.addr),
                                            req.wdata);
                    s_next.last  = req.blast;
                end
            end
            default: s_next.state = LBRI_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg       <= '0;
            s_reg.state <= LBRI_IDLE;
            s_reg.tgt   <= LBRI_TGT_NONE;
            s_reg.latch <= LBRI_IO_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign local_bus_grant = s_reg.grant;
    assign rsp.ready       = s_reg.ready;
    assign rsp.rdata       = s_reg.rdata;
    assign io_out          = s_reg.latch;

endmodule // lbri_top

// >>> lbri_properties.sv
// Checker: local-bus timing, I/O latch and decode properties
`timescale 1ns/1ps
module lbri_properties
    import lbri_pkg::*;
(
    // Watched ports
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 local_bus_request,
    input wire logic                 local_bus_grant,
    input wire lbri_req_t            req,
    input wire lbri_rsp_t            rsp,
    input wire logic [LBRI_IO_W-1:0] io_in,
    input wire logic [LBRI_IO_W-1:0] io_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    sequence s_wr; req.ads && req.write_not_read; endsequence
    sequence s_rd; req.ads && !req.write_not_read; endsequence
    sequence s_io_wr;
        req.ads && req.write_not_read && req.addr[14:1] == 14'h3000
            && req.byte_en[1:0] == 2'h3;
    endsequence
    sequence s_quiet; !(req.ads && req.write_not_read) [*4]; endsequence
    sequence s_io_rd;
        req.ads && !req.write_not_read && req.addr[14:0] == 15'h6000
            && req.byte_en[1:0] == 2'h3;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_LATENCY: assert property (req.ads |-> ##3 rsp.ready)
        else $error("ready late");
    AST_RDY_CAUSE: assert property (
        rsp.ready |-> $past(req.ads, 3) || $past(rsp.ready, 2))
        else $error("ready without access");
    AST_RDY_PULSE: assert property (rsp.ready |=> !rsp.ready)
        else $error("ready too long");
    AST_GRANT: assert property (
        1'b1 |=> local_bus_grant == $past(local_bus_request))
        else $error("grant wrong");
    AST_IO_WRITE: assert property (
        s_io_wr |-> ##3 io_out == $past(req.wdata[15:0], 3))
        else $error("latch not loaded");
    AST_IO_STABLE: assert property (s_quiet |=> $stable(io_out))
        else $error("latch moved");
    AST_UNUSED: assert property (
        s_rd ##0 req.addr[14:0] > 15'h6001
        |-> ##3 rsp.rdata == 32'h0000_0000)
        else $error("unused read not zero");
    AST_WR_ZERO: assert property (
        s_wr |-> ##3 rsp.rdata == 32'h0000_0000)
        else $error("write returned data");
    AST_IO_READ: assert property (
        s_io_rd |-> ##3 rsp.rdata == {16'h0000, $past(io_in, 1)})
        else $error("input pins not returned");
endmodule // lbri_properties

bind lbri_top lbri_properties lbri_properties_i (
    .clk(clk), .reset(reset), .local_bus_request(local_bus_request),
    .local_bus_grant(local_bus_grant), .req(req), .rsp(rsp),
    .io_in(io_in), .io_out(io_out));

// >>> lbri_bridge_model.sv
// Bridge model: owns the local bus and runs single-beat cycles
`timescale 1ns/1ps
module lbri_bridge_model
    import lbri_pkg::*;
(
    // Bus side
    input  wire logic      clk,
    output logic           local_bus_request,
    input  wire logic      local_bus_grant,
    output lbri_req_t      req,
    input  wire lbri_rsp_t rsp
);
    initial begin
        local_bus_request = 1'b0;
        req = '0;
    end
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] q, output int lat);
        int n;
        n = 0;
        @(posedge clk);
        local_bus_request <= 1'b1;
        while (!local_bus_grant && n < 8) begin
            @(posedge clk);
            n++;
        end
        req <= '{1'b1, 1'b1, wr, a, be, d};
        @(posedge clk);
        req.ads <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!rsp.ready && n < 8);
        q = rsp.rdata;
        lat = (rsp.ready && local_bus_grant) ? n : -1;
        req.addr <= ~a;
        req.wdata <= ~d;
    endtask
endmodule // lbri_bridge_model

// >>> lbri_top_bench.sv
// Testbench: RAM, I/O latch and decode scenarios on the local bus
`timescale 1ns/1ps
module lbri_top_bench;
    import lbri_pkg::*;
    logic        clk;
    logic        reset;
    logic        local_bus_request;
    logic        local_bus_grant;
    lbri_req_t   req;
    lbri_rsp_t   rsp;
    logic [15:0] io_in;
    logic [15:0] io_out;
    logic [31:0] q;
    int          error_cnt;
    int          num_checks;
    logic        n_request;
    logic        n_grant;
    lbri_req_t   n_req;
    lbri_rsp_t   n_rsp;
    logic [15:0] n_io_in;
    logic [15:0] n_io_out;
    localparam int LAT = 3;
    lbri_top lbri_top_i (.clk(clk), .reset(reset),
        .local_bus_request(local_bus_request),
        .local_bus_grant(local_bus_grant), .req(req), .rsp(rsp),
        .io_in(io_in), .io_out(io_out));
    lbri_bridge_model lbri_bridge_model_i (.clk(clk),
        .local_bus_request(local_bus_request),
        .local_bus_grant(local_bus_grant), .req(req), .rsp(rsp));
    lbri_top #(.BUS_WIDTH(LBRI_BW_8)) lbri_top_narrow_i (.clk(clk),
        .reset(reset), .local_bus_request(n_request),
        .local_bus_grant(n_grant), .req(n_req), .rsp(n_rsp),
        .io_in(n_io_in), .io_out(n_io_out));
    lbri_bridge_model lbri_bridge_model_narrow_i (.clk(clk),
        .local_bus_request(n_request), .local_bus_grant(n_grant),
        .req(n_req), .rsp(n_rsp));
    assign n_io_in = n_io_out; // Outputs bridged to inputs
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        int lt;
        lbri_bridge_model_i.xfer(1'b1, a, be, d, q, lt);
        chk("write rdata", q, 32'h0);
        chk("write latency", lt, LAT);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e,
                      input string nm);
        int lt;
        lbri_bridge_model_i.xfer(1'b0, a, 4'hf, 32'h0, q, lt);
        chk(nm, q, e);
        chk("read latency", lt, LAT);
    endtask
    task automatic nwr(input logic [31:0] a, input logic [31:0] d);
        int lt;
        lbri_bridge_model_narrow_i.xfer(1'b1, a, 4'h1, d, q, lt);
        chk("narrow write rdata", q, 32'h0);
        chk("narrow write latency", lt, LAT);
    endtask
    task automatic nrd(input logic [31:0] a, input logic [31:0] e,
                       input string nm);
        int lt;
        lbri_bridge_model_narrow_i.xfer(1'b0, a, 4'h1, 32'h0, q, lt);
        chk(nm, q, e);
        chk("narrow read latency", lt, LAT);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_ram;
        wr(32'h10, 4'hf, 32'h11223344);
        wr(32'h10, 4'h2, 32'haabbccdd);
        rd(32'h10, 32'h1122cc44, "ram lanes");
        wr(32'h5ffc, 4'hf, 32'hcafef00d);
        wr(32'h0, 4'hf, 32'h0badcafe);
        rd(32'h5ffc, 32'hcafef00d, "ram top");
        rd(32'h0, 32'h0badcafe, "ram bottom");
        chk("grant", {31'h0, local_bus_grant}, 32'h1);
        $display("test ram done");
    endtask
    task automatic t_io;
        chk("io width", $bits(lbri_top_i.io_in) + $bits(lbri_top_i.io_out),
            32'd32);
        io_in <= 16'h5a3c;
        wr(32'h6000, 4'h3, 32'h0000beef);
        chk("io_out", {16'h0, io_out}, 32'hbeef);
        rd(32'h6000, 32'h00005a3c, "io read");
        wr(32'h20, 4'hf, 32'h1);
        chk("io_out held", {16'h0, io_out}, 32'hbeef);
        io_in <= io_out;
        rd(32'h6000, 32'h0000beef, "loopback");
        wr(32'h6000, 4'h3, 32'h00001234);
        io_in <= io_out;
        rd(32'h6000, 32'h00001234, "loopback 2");
        $display("test io done");
    endtask
    task automatic t_unused;
        wr(32'h4, 4'hf, 32'h5555aaaa);
        wr(32'h6004, 4'hf, 32'hffffffff);
        wr(32'h6000, 4'hc, 32'hffff0000);
        rd(32'h6004, 32'h0, "unused");
        rd(32'h7ffc, 32'h0, "unused top");
        rd(32'h4, 32'h5555aaaa, "ram kept");
        chk("io_out kept", {16'h0, io_out}, 32'h1234);
        $display("test unused done");
    endtask
    task automatic t_narrow;
        nwr(32'h11, 32'hab);
        nwr(32'h12, 32'hcd);
        nrd(32'h11, 32'hab, "byte lane 1");
        nrd(32'h12, 32'hcd, "byte lane 2");
        nwr(32'h6000, 32'h34);
        nwr(32'h6001, 32'h12);
        chk("narrow io_out", {16'h0, n_io_out}, 32'h1234);
        nrd(32'h6001, 32'h12, "narrow loopback");
        nrd(32'h6002, 32'h0, "narrow gap");
        $display("test narrow done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        io_in = 16'h0;
        error_cnt = 0;
        num_checks = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk("reset io_out", {16'h0, io_out}, 32'h0);
        chk("reset grant", {31'h0, local_bus_grant}, 32'h0);
        chk("reset narrow io_out", {16'h0, n_io_out}, 32'h0);
        t_ram();
        t_io();
        t_unused();
        t_narrow();
        wrap_up();
    end
    initial begin
        #(40 * 2000);
        error_cnt++;
        wrap_up();
    end
endmodule // lbri_top_bench
